//--- qsg_mgmt_regs.sv
// per-channel management register bank reached over serial management pins
// assumes management clock well below core clock; status words synchronous
`timescale 1ns/1ps
`include "qsg_mgmt_params.svh"

// Overview of operation
// - frame register-address field selects the register
// - each channel has its own register set
// - undefined addresses read zero, ignore writes
// - decode addresses 0-8, 15, 16, 18
// - bit 15 resets module, then self-clears
// - reserved bit 14, and bit 11 on channels other than 0, store writes
// - bit 13 reads zero, bit 6 one
// - bit 12 enables auto-negotiation, default one
// - channel 0 bit 11 powers down, reset-only clear
// - bit 10 isolates client side, default one
// - bit 9 restarts auto-negotiation, self-clears
// - bit 8 reads one, full duplex
// - bit 7 reads zero, collision test off
// - bit 5 allows transmit without link
// - bits 4 to 0 read zero
// - register-address field is five bits wide
// - write frame stores sixteen data bits
// - read frame drives turnaround zero, then data
module qsg_mgmt_regs
  import qsg_mgmt_pkg::*;
#(
  parameter int NCH = 4,
  parameter logic [15:0] ID_HI = 16'h1234, // arbitrary identity value
  parameter logic [15:0] ID_LO = 16'h5678 // arbitrary identity value
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [NCH-1:0] mdc_i,
  input wire logic [NCH-1:0] mdio_i,
  output logic [NCH-1:0] mdio_o,
  output logic [NCH-1:0] mdio_oe_o,
  input wire logic [NCH-1:0][4:0] phyad_i,
  input qsg_stat_t [NCH-1:0] stat_i,
  output qsg_ctrl_t [NCH-1:0] ctrl_o,
  output qsg_cfg_t [NCH-1:0] cfg_o,
  output logic [NCH-1:0] status_read_o
);

  logic [NCH-1:0] mdc_s;
  logic [NCH-1:0] mdio_s;

  // read multiplexer shared by every channel
  function automatic logic [15:0] rd_mux(
    input logic [4:0] regad,
    input logic [15:0] ctrl_rd,
    input qsg_cfg_t cfg,
    input qsg_stat_t st
  );
    logic [15:0] r;
    r = 16'h0000;
    unique case (regad)
      `QSG_REG_CTRL: r = ctrl_rd;
      `QSG_REG_STATUS: r = st.status;
      `QSG_REG_ID_HI: r = ID_HI;
      `QSG_REG_ID_LO: r = ID_LO;
      `QSG_REG_ADV: r = cfg.advert;
      `QSG_REG_PARTNER: r = st.partner;
      `QSG_REG_EXPAN: r = st.expansion;
      `QSG_REG_NP_TX: r = cfg.np_tx;
      `QSG_REG_NP_RX: r = st.np_rx;
      `QSG_REG_EXT: r = st.ext_status;
      `QSG_REG_IRQ: r = cfg.irq_ctrl;
      `QSG_REG_GENERIC: r = cfg.generic;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  // pins from the management master are asynchronous to the core
  qsg_sync #(
    .WIDTH(2 * NCH)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .async_i({mdc_i, mdio_i}),
    .sync_o({mdc_s, mdio_s})
  );

  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    logic mdc_d_q;
    logic rise;
    logic bit_in;
    qsg_fstate_t state_q;
    logic [3:0] cnt_q;
    logic [11:0] hdr_q;
    logic [15:0] sh_q;
    logic one_q;
    logic rd_q;
    logic hit_q;
    logic [4:0] regad_q;
    logic wr_q;
    logic [4:0] wreg_q;
    logic [15:0] wdat_q;
    logic [15:0] ctrl_rd;
    logic ctrl_wr;
    logic [4:0] hdr_reg;
    logic [4:0] hdr_phy;
    logic [1:0] hdr_op;
    logic hdr_hit;
    qsg_cfg_t cfg_q;

    assign rise = mdc_s[ch] & ~mdc_d_q;
    assign bit_in = mdio_s[ch];
    // header seen on its last bit: op, phy address, register address
    assign hdr_op = hdr_q[10:9];
    assign hdr_phy = hdr_q[8:4];
    assign hdr_reg = {hdr_q[3:0], bit_in};
    assign hdr_hit = (hdr_phy == phyad_i[ch]) ||
                     (hdr_phy == `QSG_BCAST_PHYAD);
    assign ctrl_wr = wr_q && (wreg_q == `QSG_REG_CTRL);

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        mdc_d_q <= 1'b0;
      end else begin
        mdc_d_q <= mdc_s[ch];
      end
    end

    // frame sequencer, advanced on each rising management clock
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        state_q <= QSG_IDLE;
        cnt_q <= 4'h0;
        hdr_q <= 12'h000;
        one_q <= 1'b0;
        rd_q <= 1'b0;
        hit_q <= 1'b0;
        regad_q <= 5'h00;
      end else if (rise) begin
        unique case (state_q)
          QSG_IDLE: begin
            one_q <= bit_in;
            if (!bit_in && one_q) begin
              state_q <= QSG_START;
            end
          end
          QSG_START: begin
            one_q <= bit_in;
            cnt_q <= 4'h0;
            state_q <= bit_in ? QSG_HEAD : QSG_IDLE;
          end
          QSG_HEAD: begin
            hdr_q <= {hdr_q[10:0], bit_in};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `QSG_HDR_LAST) begin
              regad_q <= hdr_reg;
              rd_q <= (hdr_op == `QSG_OP_READ);
              hit_q <= hdr_hit && ((hdr_op == `QSG_OP_READ) ||
                                   (hdr_op == `QSG_OP_WRITE));
              cnt_q <= 4'h0;
              state_q <= QSG_TA;
            end
          end
          QSG_TA: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h1) begin
              cnt_q <= 4'h0;
              state_q <= QSG_DATA;
            end
          end
          QSG_DATA: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `QSG_DATA_LAST) begin
              cnt_q <= 4'h0;
              one_q <= 1'b0;
              state_q <= QSG_IDLE;
            end
          end
        endcase
      end
    end

    // data shifter: read word loaded at header end, write word collected
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        sh_q <= 16'h0000;
      end else if (rise) begin
        if (state_q == QSG_HEAD && cnt_q == `QSG_HDR_LAST) begin
          sh_q <= rd_mux(hdr_reg, ctrl_rd, cfg_q, stat_i[ch]);
        end else if (state_q == QSG_TA && cnt_q == 4'h1 && rd_q) begin
          sh_q <= {sh_q[14:0], 1'b0};
        end else if (state_q == QSG_DATA) begin
          sh_q <= rd_q ? {sh_q[14:0], 1'b0} : {sh_q[14:0], bit_in};
        end
      end
    end

    // pin driver: zero in second turnaround bit, then sixteen data bits
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        mdio_o[ch] <= 1'b0;
        mdio_oe_o[ch] <= 1'b0;
      end else if (rise && rd_q && hit_q) begin
        if (state_q == QSG_TA && cnt_q == 4'h0) begin
          mdio_o[ch] <= 1'b0;
          mdio_oe_o[ch] <= 1'b1;
        end else if (state_q == QSG_TA) begin
          mdio_o[ch] <= sh_q[15];
        end else if (state_q == QSG_DATA) begin
          mdio_o[ch] <= sh_q[15];
          if (cnt_q == `QSG_DATA_LAST) begin
            mdio_o[ch] <= 1'b0;
            mdio_oe_o[ch] <= 1'b0;
          end
        end
      end else if (rise && state_q != QSG_TA && state_q != QSG_DATA) begin
        mdio_oe_o[ch] <= 1'b0;
      end
    end

    // write strobe raised once the last data bit is in
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        wr_q <= 1'b0;
        wreg_q <= 5'h00;
        wdat_q <= 16'h0000;
      end else begin
        wr_q <= rise && state_q == QSG_DATA && cnt_q == `QSG_DATA_LAST &&
                !rd_q && hit_q;
        if (rise && state_q == QSG_DATA && cnt_q == `QSG_DATA_LAST) begin
          wreg_q <= regad_q;
          wdat_q <= {sh_q[14:0], bit_in};
        end
      end
    end

    // status register read notice for read-clearing bits held elsewhere
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        status_read_o[ch] <= 1'b0;
      end else begin
        status_read_o[ch] <= rise && state_q == QSG_HEAD &&
                             cnt_q == `QSG_HDR_LAST && hdr_hit &&
                             hdr_op == `QSG_OP_READ &&
                             hdr_reg == `QSG_REG_STATUS;
      end
    end

    // writable registers other than control; others ignore writes
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cfg_q.advert <= `QSG_RST_ADV;
        cfg_q.np_tx <= `QSG_RST_NP_TX;
        cfg_q.irq_ctrl <= `QSG_RST_IRQ;
        cfg_q.generic <= `QSG_RST_GENERIC;
      end else if (wr_q) begin
        unique case (wreg_q)
          `QSG_REG_ADV: cfg_q.advert <= wdat_q;
          `QSG_REG_NP_TX: cfg_q.np_tx <= wdat_q;
          `QSG_REG_IRQ: cfg_q.irq_ctrl <= wdat_q;
          `QSG_REG_GENERIC: cfg_q.generic <= wdat_q;
          default: cfg_q.generic <= cfg_q.generic;
        endcase
      end
    end

    assign cfg_o[ch] = cfg_q;

    // bits 13, 8, 7, 6 and 4:0 are fixed inside the control register
    qsg_ctrl_reg #(
      .HAS_PDOWN(ch == 0)
    ) u_ctrl (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .wr_i(ctrl_wr),
      .wdata_i(wdat_q),
      .rdata_o(ctrl_rd),
      .ctrl_o(ctrl_o[ch])
    );
  end

endmodule // qsg_mgmt_regs

//--- qsg_mgmt_params.svh
// constants for the per-channel management register bank
// assumes inclusion by qsg_mgmt_regs and qsg_ctrl_reg, not by the package or qsg_sync
`ifndef QSG_MGMT_PARAMS_SVH
`define QSG_MGMT_PARAMS_SVH

// register addresses
`define QSG_REG_CTRL 5'h00
`define QSG_REG_STATUS 5'h01
`define QSG_REG_ID_HI 5'h02
`define QSG_REG_ID_LO 5'h03
`define QSG_REG_ADV 5'h04
`define QSG_REG_PARTNER 5'h05
`define QSG_REG_EXPAN 5'h06
`define QSG_REG_NP_TX 5'h07
`define QSG_REG_NP_RX 5'h08
`define QSG_REG_EXT 5'h0f
`define QSG_REG_IRQ 5'h10
`define QSG_REG_GENERIC 5'h12

// control register field positions
`define QSG_B_RESET 15
`define QSG_B_RSVD14 14
`define QSG_B_SPEED_LSB 13
`define QSG_B_AN_EN 12
`define QSG_B_PDOWN 11
`define QSG_B_ISOLATE 10
`define QSG_B_RESTART 9
`define QSG_B_DUPLEX 8
`define QSG_B_COLTEST 7
`define QSG_B_SPEED_MSB 6
`define QSG_B_UNIDIR 5

// control register reset and fixed values
`define QSG_RST_RSVD14 1'b0
`define QSG_RST_AN_EN 1'b1
`define QSG_RST_B11 1'b0
`define QSG_RST_ISOLATE 1'b1
`define QSG_RST_UNIDIR 1'b0
`define QSG_FIX_SPEED_LSB 1'b0
`define QSG_FIX_DUPLEX 1'b1
`define QSG_FIX_COLTEST 1'b0
`define QSG_FIX_SPEED_MSB 1'b1
`define QSG_FIX_LOW 5'h00

// writable register reset values
`define QSG_RST_ADV 16'h0000
`define QSG_RST_NP_TX 16'h0000
`define QSG_RST_IRQ 16'h0000
`define QSG_RST_GENERIC 16'h0000

// frame fields and timing
`define QSG_OP_WRITE 2'h1
`define QSG_OP_READ 2'h2
`define QSG_BCAST_PHYAD 5'h00
`define QSG_HDR_LAST 4'hb
`define QSG_DATA_LAST 4'hf
`define QSG_MOD_RST_CYCLES 8'h10

`endif

//--- qsg_mgmt_pkg.sv
// types shared by the management register bank
// assumes qsg_mgmt_params.svh is on the include path
package qsg_mgmt_pkg;

  typedef enum logic [2:0] {
    QSG_IDLE = 3'b000,
    QSG_START = 3'b001,
    QSG_HEAD = 3'b010,
    QSG_TA = 3'b011,
    QSG_DATA = 3'b100
  } qsg_fstate_t;

  typedef struct packed {
    logic module_reset;
    logic an_enable;
    logic isolate;
    logic power_down;
    logic an_restart;
    logic unidir;
  } qsg_ctrl_t;

  typedef struct packed {
    logic [15:0] advert;
    logic [15:0] np_tx;
    logic [15:0] irq_ctrl;
    logic [15:0] generic;
  } qsg_cfg_t;

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] partner;
    logic [15:0] expansion;
    logic [15:0] np_rx;
    logic [15:0] ext_status;
  } qsg_stat_t;

endpackage

//--- qsg_sync.sv
// two-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level or a pin, not a multi-bit word
`timescale 1ns/1ps
module qsg_sync #(
  parameter int WIDTH = 2
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        meta_q[i] <= 1'b0;
        sync_o[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_i[i];
        sync_o[i] <= meta_q[i];
      end
    end
  end

endmodule // qsg_sync

//--- qsg_ctrl_reg.sv
// control register of one channel with module reset sequencing
// assumes write strobe and data come from the same clock domain
`timescale 1ns/1ps
`include "qsg_mgmt_params.svh"
module qsg_ctrl_reg
  import qsg_mgmt_pkg::*;
#(
  parameter bit HAS_PDOWN = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output qsg_ctrl_t ctrl_o
);

  logic rst_q;
  logic [7:0] rst_cnt_q;
  logic rsvd14_q;
  logic an_en_q;
  logic b11_q;
  logic iso_q;
  logic restart_q;
  logic unidir_q;

  // module reset held for a fixed count, then bit 15 clears
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q <= 1'b0;
      rst_cnt_q <= 8'h00;
    end else if (rst_q) begin
      rst_cnt_q <= rst_cnt_q - 8'h01;
      if (rst_cnt_q == 8'h00) begin
        rst_q <= 1'b0;
      end
    end else if (wr_i && wdata_i[`QSG_B_RESET]) begin
      rst_q <= 1'b1;
      rst_cnt_q <= `QSG_MOD_RST_CYCLES - 8'h01;
    end
  end

  // writable fields; module reset forces defaults
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsvd14_q <= `QSG_RST_RSVD14;
      an_en_q <= `QSG_RST_AN_EN;
      iso_q <= `QSG_RST_ISOLATE;
      unidir_q <= `QSG_RST_UNIDIR;
    end else if (rst_q) begin
      rsvd14_q <= `QSG_RST_RSVD14;
      an_en_q <= `QSG_RST_AN_EN;
      iso_q <= `QSG_RST_ISOLATE;
      unidir_q <= `QSG_RST_UNIDIR;
    end else if (wr_i) begin
      rsvd14_q <= wdata_i[`QSG_B_RSVD14];
      an_en_q <= wdata_i[`QSG_B_AN_EN];
      iso_q <= wdata_i[`QSG_B_ISOLATE];
      unidir_q <= wdata_i[`QSG_B_UNIDIR];
    end
  end

  // bit 11: sticky power down on channel 0, plain storage elsewhere
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      b11_q <= `QSG_RST_B11;
    end else if (rst_q) begin
      b11_q <= `QSG_RST_B11;
    end else if (wr_i) begin
      if (HAS_PDOWN) begin
        b11_q <= b11_q | wdata_i[`QSG_B_PDOWN];
      end else begin
        b11_q <= wdata_i[`QSG_B_PDOWN];
      end
    end
  end

  // restart is a one-cycle self-clearing bit
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_i && !rst_q && wdata_i[`QSG_B_RESTART];
    end
  end

  // constant bits are wired, never stored
  assign rdata_o = {rst_q, rsvd14_q, `QSG_FIX_SPEED_LSB, an_en_q, b11_q,
                    iso_q, restart_q, `QSG_FIX_DUPLEX, `QSG_FIX_COLTEST,
                    `QSG_FIX_SPEED_MSB, unidir_q, `QSG_FIX_LOW};

  assign ctrl_o.module_reset = rst_q;
  assign ctrl_o.an_enable = an_en_q;
  assign ctrl_o.isolate = iso_q;
  assign ctrl_o.power_down = HAS_PDOWN ? b11_q : 1'b0;
  assign ctrl_o.an_restart = restart_q;
  assign ctrl_o.unidir = unidir_q;

endmodule // qsg_ctrl_reg

//--- qsg_mgmt_regs_props.sv
// port checker for the management register bank
// assumes bind onto qsg_mgmt_regs, single core clock domain
`timescale 1ns/1ps
module qsg_mgmt_regs_props
  import qsg_mgmt_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [NCH-1:0] mdc_i,
  input wire logic [NCH-1:0] mdio_i,
  input wire logic [NCH-1:0] mdio_o,
  input wire logic [NCH-1:0] mdio_oe_o,
  input wire logic [NCH-1:0][4:0] phyad_i,
  input qsg_stat_t [NCH-1:0] stat_i,
  input qsg_ctrl_t [NCH-1:0] ctrl_o,
  input qsg_cfg_t [NCH-1:0] cfg_o,
  input wire logic [NCH-1:0] status_read_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic [NCH-1:0] mdc_q;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) mdc_q <= '0;
    else mdc_q <= mdc_i;
  end
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [4:0] rst_cnt_q;
    logic [4:0] rise_cnt_q;
    // length of module reset
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) rst_cnt_q <= '0;
      else if (ctrl_o[c].module_reset) rst_cnt_q <= rst_cnt_q + 5'h01;
      else rst_cnt_q <= '0;
    end
    // clock rises seen while driving
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) rise_cnt_q <= '0;
      else if (!mdio_oe_o[c]) rise_cnt_q <= '0;
      else if (mdc_i[c] & ~mdc_q[c]) rise_cnt_q <= rise_cnt_q + 5'h01;
    end
    sequence s_turn;
      $rose(mdio_oe_o[c]) && !mdio_o[c];
    endsequence
    sequence s_rst_done;
      $fell(ctrl_o[c].module_reset);
    endsequence
    rst_len_a: assert property (s_rst_done |-> rst_cnt_q == 5'h10)
      else $error("module reset length wrong");
    rst_defaults_a: assert property (s_rst_done |->
      ctrl_o[c].an_enable && ctrl_o[c].isolate && !ctrl_o[c].power_down
      && !ctrl_o[c].unidir) else $error("reset defaults not restored");
    pdown_sticky_a: assert property ($fell(ctrl_o[c].power_down) |->
      ctrl_o[c].module_reset || $past(ctrl_o[c].module_reset))
      else $error("power down cleared without reset");
    restart_pulse_a: assert property ($rose(ctrl_o[c].an_restart) |=>
      !ctrl_o[c].an_restart) else $error("restart not a pulse");
    ta_zero_a: assert property ($rose(mdio_oe_o[c]) |->
      !mdio_o[c] ##1 mdio_oe_o[c] [*8]) else $error("turnaround wrong");
    read_len_a: assert property ($fell(mdio_oe_o[c]) |->
      rise_cnt_q == 5'h11) else $error("read drive length wrong");
    stat_read_a: assert property (status_read_o[c] |->
      ##[1:1000] s_turn) else $error("status read without answer");
    if (c > 0) begin : g_np
      pdown_only0_a: assert property (!ctrl_o[c].power_down)
        else $error("power down on other channel");
    end
  end
endmodule // qsg_mgmt_regs_props

bind qsg_mgmt_regs qsg_mgmt_regs_props #(.NCH(NCH)) u_props (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .mdc_i(mdc_i),
  .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
  .phyad_i(phyad_i), .stat_i(stat_i), .ctrl_o(ctrl_o), .cfg_o(cfg_o),
  .status_read_o(status_read_o)
);

//--- qsg_sta_model.sv
// station management master model, one frame at a time
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ps
module qsg_sta_model #(
  parameter int NCH = 4,
  parameter int HALF = 40
) (
  input wire logic core_clk_i,
  input wire logic [NCH-1:0] mdio_i,
  output logic [NCH-1:0] mdc_o,
  output logic [NCH-1:0] drv_o,
  output logic [NCH-1:0] dout_o
);
  initial begin
    mdc_o = '0;
    drv_o = '0;
    dout_o = '0;
  end
  task automatic frame(input int ch, input logic [1:0] op,
      input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [32:0] bits;
    bits = {1'b1, 2'b01, op, pa, ra, 2'b10, wd};
    rd = '0;
    for (int k = 0; k < 33; k++) begin
      @(posedge core_clk_i);
      mdc_o[ch] <= 1'b0;
      drv_o[ch] <= (op == 2'h1) || (k < 15);
      dout_o[ch] <= bits[32-k];
      repeat (HALF - 1) @(posedge core_clk_i);
      if (op != 2'h1 && k > 16) rd = {rd[14:0], mdio_i[ch]};
      mdc_o[ch] <= 1'b1;
      repeat (HALF) @(posedge core_clk_i);
    end
    @(posedge core_clk_i);
    mdc_o[ch] <= 1'b0;
    drv_o[ch] <= 1'b0;
    repeat (HALF) @(posedge core_clk_i);
  endtask
endmodule // qsg_sta_model

//--- testbench.sv
// self-checking bench for the management register bank
// assumes the station model and checker are compiled before it
`timescale 1ns/1ps
module testbench
  import qsg_mgmt_pkg::*;
;
  localparam logic [15:0] ID_A = 16'h2a51; // arbitrary value
  localparam logic [15:0] ID_B = 16'h6c0e; // arbitrary value
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] mdc, drv, dout, mdio_w, mdio_o, mdio_oe, sread;
  logic [3:0][4:0] phyad;
  qsg_stat_t [3:0] stat;
  qsg_ctrl_t [3:0] ctrl;
  qsg_cfg_t [3:0] cfg;
  int n_mismatch = 0;
  int check_count = 0;
  int n_restart = 0;
  int n_sread = 0;
  logic [31:0] seed = 32'h92448a5b;
  logic [15:0] ctrlm[4];
  logic [15:0] regm[4][32];
  logic [4:0] tbl[12] = '{5'h04, 5'h07, 5'h12, 5'h09, 5'h1f, 5'h01,
    5'h0f, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08};
  always #2.5 clk = ~clk;
  // count restart pulses and status read notices seen on any channel
  always @(posedge clk) begin
    n_restart <= n_restart + $countones({ctrl[3].an_restart,
      ctrl[2].an_restart, ctrl[1].an_restart, ctrl[0].an_restart});
    n_sread <= n_sread + $countones(sread);
  end
  assign mdio_w = (mdio_oe & mdio_o) | (~mdio_oe & drv & dout)
    | (~mdio_oe & ~drv);
  qsg_mgmt_regs #(.NCH(4), .ID_HI(ID_A), .ID_LO(ID_B)) dut (
    .core_clk_i(clk), .nrst_i(nrst), .mdc_i(mdc), .mdio_i(mdio_w),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe), .phyad_i(phyad),
    .stat_i(stat), .ctrl_o(ctrl), .cfg_o(cfg), .status_read_o(sread)
  );
  qsg_sta_model #(.NCH(4)) sta (
    .core_clk_i(clk), .mdio_i(mdio_w), .mdc_o(mdc), .drv_o(drv),
    .dout_o(dout)
  );
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] exp_rd(int ch, logic [4:0] ad);
    case (ad)
      5'h00: return ctrlm[ch] | 16'h0140;
      5'h01: return stat[ch].status;
      5'h02: return ID_A;
      5'h03: return ID_B;
      5'h05: return stat[ch].partner;
      5'h06: return stat[ch].expansion;
      5'h08: return stat[ch].np_rx;
      5'h0f: return stat[ch].ext_status;
      default: return regm[ch][ad];
    endcase
  endfunction
  task automatic wr(int ch, logic [4:0] ad, logic [15:0] w,
      logic [4:0] pa);
    logic [15:0] rd;
    logic [15:0] m;
    qsg_ctrl_t c;
    sta.frame(ch, 2'h1, pa, ad, w, rd);
    if (pa == phyad[ch] || pa == 5'h00) begin
      if (ad == 5'h00)
        ctrlm[ch] = w[15] ? 16'h1400 : (w & 16'h5c20)
          | (ch == 0 ? ctrlm[ch] & 16'h0800 : 16'h0000);
      else if (ad inside {5'h04, 5'h07, 5'h10, 5'h12}) regm[ch][ad] = w;
    end
    for (int k = 0; k < 4; k++) begin
      c = ctrl[k];
      m = ctrlm[k];
      chk({c.module_reset, c.an_restart, c.an_enable, c.isolate,
        c.power_down, c.unidir}, {2'b00, m[12], m[10], m[11] & (k == 0),
        m[5]});
      chk(cfg[k], {regm[k][4], regm[k][7], regm[k][16], regm[k][18]});
    end
  endtask
  task automatic rd_chk(int ch, logic [4:0] ad);
    logic [15:0] rd;
    sta.frame(ch, 2'h2, phyad[ch], ad, 16'h0000, rd);
    chk(rd, exp_rd(ch, ad));
  endtask
  function automatic logic [15:0] rnd_ctrl();
    return (16'(xs()) | 16'h68bf) & 16'h7cbf;
  endfunction
  initial begin
    for (int c = 0; c < 4; c++) begin
      phyad[c] = 5'(c + 9);
      stat[c] = 80'({xs(), xs(), xs()});
      ctrlm[c] = 16'h1400;
      for (int a = 0; a < 32; a++) regm[c][a] = 16'h0000;
    end
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    rd_chk(0, 5'h00);
    rd_chk(3, 5'h00);
    wr(3, 5'h00, rnd_ctrl(), phyad[3]);
    rd_chk(3, 5'h00);
    rd_chk(0, 5'h00);
    wr(0, 5'h00, rnd_ctrl(), phyad[0]);
    rd_chk(0, 5'h00);
    wr(0, 5'h00, 16'h0000, phyad[0]);
    wr(0, 5'h00, 16'h8000, phyad[0]);
    rd_chk(0, 5'h00);
    wr(0, 5'h00, 16'h0200, phyad[0]);
    rd_chk(0, 5'h00);
    chk(n_restart, 1);
    wr(1, 5'h04, 16'(xs()), 5'h1f);
    wr(1, 5'h10, 16'(xs()), 5'h00);
    rd_chk(1, 5'h04);
    rd_chk(1, 5'h10);
    for (int i = 0; i < 7; i++) wr(2, tbl[i], 16'(xs()), phyad[2]);
    for (int i = 0; i < 12; i++) rd_chk(2, tbl[i]);
    chk(n_sread, 1);
    close_out();
  end
  initial begin
    repeat (99000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
endmodule // testbench
